// >>> design/uart_shadow_pkg.sv
// constants and carrier types for the uart shadow data port
package uart_shadow_pkg;
  // register byte addresses
  localparam logic [31:0] DATA_ADDR = 32'h5000_1064;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1100;
  localparam logic [31:0] DIV_ADDR = 32'h5000_1104;
  localparam logic [31:0] LINE_ADDR = 32'h5000_1108;
  localparam logic [31:0] ISTAT_ADDR = 32'h5000_110c;
  localparam logic [31:0] IMASK_ADDR = 32'h5000_1110;
  // control field positions
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;
  // line state field positions
  localparam int LINE_RX_VALID_BIT = 0;
  localparam int LINE_TX_EMPTY_BIT = 5;
  localparam int LINE_TX_IDLE_BIT = 6;
  // interrupt status field positions
  localparam int EV_RX_BYTE = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_TX_EMPTY = 2;
  localparam int EV_WRITE_LOST = 3;
  localparam int EV_COUNT = 4;
  // reset values
  localparam logic [15:0] DIV_RESET = 16'h0004;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] IMASK_RESET = 4'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // serial timing in oversample ticks
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] MID_LAST = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  // infrared receive pulse is stretched this many ticks to cover mid-bit
  localparam logic [3:0] IR_HOLD_TICKS = 4'hb;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic irMode;
    logic fifoEnable;
  } ctrl_t;

  typedef struct packed {
    logic txIdle;
    logic txHoldEmpty;
    logic rxDataValid;
  } lineState_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_START,
    S_DATA,
    S_STOP
  } serState_t;
endpackage

// >>> design/uart_shadow_port.sv
// uart shadow data port with fifos, serial/infrared line and avalon slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - data location answers at its alias address as a 32-bit word
// - reads return received byte in low eight bits, serial or infrared input
// - fifos off: unread byte is overwritten by next, overrun flagged
// - fifos on: read returns oldest entry at receive fifo head
// - receive fifo full: keep contents, drop incoming byte, flag overrun
// - fifos off: writing one byte clears the holding empty flag
// - fifos off: later writes replace the pending byte until empty again
// - fifos on: accept writes up to configured depth, default sixteen
// - writes while transmit fifo full are discarded, contents unchanged
// - written bytes go out on serial output or active-low infrared output
module uart_shadow_port
  import uart_shadow_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic clockEnable, // freezes all state while low
  input wire logic [31:0] address, // avalon byte address
  input wire logic read, // avalon read request
  input wire logic write, // avalon write request
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte enables
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait request
  input wire logic serialIn, // serial receive pin
  input wire logic irIn, // infrared receive pin, high pulse marks a zero
  output logic serialOut, // serial transmit pin
  output logic irOutN, // infrared transmit pin, active low
  output logic irq // level interrupt
);
  localparam int RXP = $clog2(RX_DEPTH);
  localparam int TXP = $clog2(TX_DEPTH);
  localparam int RXC = $clog2(RX_DEPTH + 1);
  localparam int TXC = $clog2(TX_DEPTH + 1);
  localparam logic [RXC-1:0] RX_FULL = RXC'(RX_DEPTH);
  localparam logic [TXC-1:0] TX_FULL = TXC'(TX_DEPTH);
  // storage and state
  logic [7:0] rxMem [RX_DEPTH];
  logic [7:0] txMem [TX_DEPTH];
  logic [RXP-1:0] rxWr_q, rxRd_q;
  logic [TXP-1:0] txWr_q, txRd_q;
  logic [RXC-1:0] rxCount_q;
  logic [TXC-1:0] txCount_q;
  ctrl_t ctrl_q;
  logic [15:0] div_q, divCnt_q;
  logic [EV_COUNT-1:0] istat_q, imask_q;
  logic [31:0] readdata_q;
  logic rdAck_q;
  logic [1:0] serSync_q, irSync_q;
  serState_t rxState_q, txState_q;
  logic [3:0] rxTick_q, txTick_q, irHold_q;
  logic [2:0] rxBit_q, txBit_q;
  logic [7:0] rxShift_q, txShift_q;
  logic rxArrive_q;
  logic serialOut_q, irOutN_q;
  // address decode
  wire selData = address == DATA_ADDR;
  wire selCtrl = address == CTRL_ADDR;
  wire selDiv = address == DIV_ADDR;
  wire selLine = address == LINE_ADDR;
  wire selIstat = address == ISTAT_ADDR;
  wire selImask = address == IMASK_ADDR;
  wire wrEn = clockEnable & write;
  wire rdTake = clockEnable & read & rdAck_q;
  // reads take one wait cycle so that read data comes from a flop
  assign waitrequest = read & ~rdAck_q;
  assign readdata = readdata_q;
  // line state view
  lineState_t line;
  assign line.rxDataValid = rxCount_q != '0;
  assign line.txHoldEmpty = txCount_q == '0;
  assign line.txIdle = txState_q == S_IDLE;
  // oversample tick from the divisor
  wire tick = clockEnable & (divCnt_q == 16'h0000);
  // receive line choice: a stretched infrared pulse marks a zero bit
  // line select
  wire irZero = irSync_q[1] | (irHold_q != 4'h0);
  wire rxLine = ctrl_q.irMode ? ~irZero : serSync_q[1];
  // receive fifo control
  wire rxFull = rxCount_q == RX_FULL;
  wire rxPop = rdTake & selData & line.rxDataValid;
  wire rxOverwrite = rxArrive_q & ~ctrl_q.fifoEnable & (rxCount_q != '0) & ~rxPop;
  wire rxDrop = rxArrive_q & ctrl_q.fifoEnable & rxFull & ~rxPop;
  wire rxPush = rxArrive_q & ~rxOverwrite & ~rxDrop;
  wire overrunEv = rxOverwrite | rxDrop;
  wire [RXP-1:0] rxWrAddr = rxOverwrite ? rxRd_q : rxWr_q;
  // transmit fifo control
  wire txFull = txCount_q == TX_FULL;
  wire txWrite = wrEn & selData & byteenable[0];
  wire txLoad = clockEnable & (txState_q == S_IDLE) & ~line.txHoldEmpty;
  wire txOverwrite = txWrite & ~ctrl_q.fifoEnable & ~line.txHoldEmpty & ~txLoad;
  wire txLost = txWrite & ctrl_q.fifoEnable & txFull & ~txLoad;
  wire txPush = txWrite & ~txOverwrite & ~txLost;
  wire [TXP-1:0] txWrAddr = txOverwrite ? txRd_q : txWr_q;
  wire txEmptyEv = txLoad & ~txPush & (txCount_q == TXC'(1));
  // event vector and interrupt
  wire [EV_COUNT-1:0] events = {txLost, txEmptyEv, overrunEv, rxArrive_q};
  assign irq = |(istat_q & imask_q);
  // read mux
  logic [31:0] rdMux;
  assign rdMux = selData ? {24'h000000, line.rxDataValid ? rxMem[rxRd_q] : 8'h00} :
                 selCtrl ? {30'h0, ctrl_q} :
                 selDiv ? {16'h0000, div_q} :
                 selLine ? {25'h0, line.txIdle, line.txHoldEmpty, 4'h0, line.rxDataValid} :
                 selIstat ? {28'h0, istat_q} :
                 selImask ? {28'h0, imask_q} : 32'h0000_0000;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdAck_q <= 1'b0;
      readdata_q <= RDATA_RESET;
    end
    else if (clockEnable)
    begin
      rdAck_q <= read & ~rdAck_q;
      if (read & ~rdAck_q)
        readdata_q <= rdMux;
    end
  end
  // software registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RESET;
      div_q <= DIV_RESET;
      imask_q <= IMASK_RESET;
    end
    else if (wrEn)
    begin
      if (selCtrl & byteenable[0])
        ctrl_q <= writedata[1:0];
      if (selDiv & byteenable[0])
        div_q[7:0] <= writedata[7:0];
      if (selDiv & byteenable[1])
        div_q[15:8] <= writedata[15:8];
      if (selImask & byteenable[0])
        imask_q <= writedata[EV_COUNT-1:0];
    end
  end
  // sticky status, a new event wins over the clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      istat_q <= '0;
    else if (clockEnable)
      istat_q <= (istat_q & ~((wrEn & selIstat & byteenable[0]) ? writedata[EV_COUNT-1:0] : '0)) | events;
  end
  // input synchronisers
  // infrared pulse stretch
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      serSync_q <= 2'h3;
      irSync_q <= 2'h0;
      irHold_q <= 4'h0;
    end
    else if (clockEnable)
    begin
      serSync_q <= {serSync_q[0], serialIn};
      irSync_q <= {irSync_q[0], irIn};
      irHold_q <= irSync_q[1] ? IR_HOLD_TICKS : irHold_q - 4'(tick & (irHold_q != 4'h0));
    end
  end
  // divisor counter
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      divCnt_q <= 16'h0000;
    else if (clockEnable)
      divCnt_q <= (divCnt_q == 16'h0000) ? div_q - 16'h0001 : divCnt_q - 16'h0001;
  end
  // receiver, 8 data bits, one stop bit, 16x oversampling
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rxState_q <= S_IDLE;
      rxTick_q <= 4'h0;
      rxBit_q <= 3'h0;
      rxShift_q <= 8'h00;
      rxArrive_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      rxArrive_q <= 1'b0;
      case (rxState_q)
        S_IDLE:
        begin
          rxTick_q <= 4'h0;
          if (!rxLine)
            rxState_q <= S_START;
        end
        S_START:
          if (tick)
          begin
            rxTick_q <= rxTick_q + 4'h1;
            if (rxTick_q == MID_LAST)
            begin
              rxTick_q <= 4'h0;
              rxBit_q <= 3'h0;
              rxState_q <= rxLine ? S_IDLE : S_DATA;
            end
          end
        S_DATA:
          if (tick)
          begin
            rxTick_q <= rxTick_q + 4'h1;
            if (rxTick_q == OVS_LAST)
            begin
              rxShift_q <= {rxLine, rxShift_q[7:1]};
              rxBit_q <= rxBit_q + 3'h1;
              if (rxBit_q == LAST_BIT)
                rxState_q <= S_STOP;
            end
          end
        S_STOP:
          if (tick)
          begin
            rxTick_q <= rxTick_q + 4'h1;
            if (rxTick_q == OVS_LAST)
            begin
              rxArrive_q <= 1'b1;
              rxState_q <= S_IDLE;
            end
          end
        default:
          rxState_q <= S_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rxWr_q <= '0;
      rxRd_q <= '0;
      rxCount_q <= '0;
    end
    else if (clockEnable)
    begin
      if (rxPush)
        rxWr_q <= (rxWr_q == RXP'(RX_DEPTH - 1)) ? '0 : rxWr_q + RXP'(1);
      if (rxPop)
        rxRd_q <= (rxRd_q == RXP'(RX_DEPTH - 1)) ? '0 : rxRd_q + RXP'(1);
      rxCount_q <= rxCount_q + RXC'(rxPush) - RXC'(rxPop);
    end
  end
  // receive storage
  always_ff @(posedge clock)
    if (clockEnable & (rxPush | rxOverwrite))
      rxMem[rxWrAddr] <= rxShift_q;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      txWr_q <= '0;
      txRd_q <= '0;
      txCount_q <= '0;
    end
    else if (clockEnable)
    begin
      if (txPush)
        txWr_q <= (txWr_q == TXP'(TX_DEPTH - 1)) ? '0 : txWr_q + TXP'(1);
      if (txLoad)
        txRd_q <= (txRd_q == TXP'(TX_DEPTH - 1)) ? '0 : txRd_q + TXP'(1);
      txCount_q <= txCount_q + TXC'(txPush) - TXC'(txLoad);
    end
  end
  // transmit storage, only the low byte is kept
  always_ff @(posedge clock)
    if (txPush | txOverwrite)
      txMem[txWrAddr] <= writedata[7:0];
  // transmitter, 8 data bits, one stop bit
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      txState_q <= S_IDLE;
      txTick_q <= 4'h0;
      txBit_q <= 3'h0;
      txShift_q <= 8'h00;
    end
    else if (clockEnable)
    begin
      case (txState_q)
        S_IDLE:
        begin
          txTick_q <= 4'h0;
          txBit_q <= 3'h0;
          if (txLoad)
          begin
            txShift_q <= txMem[txRd_q];
            txState_q <= S_START;
          end
        end
        S_START:
          if (tick)
          begin
            txTick_q <= txTick_q + 4'h1;
            if (txTick_q == OVS_LAST)
              txState_q <= S_DATA;
          end
        S_DATA:
          if (tick)
          begin
            txTick_q <= txTick_q + 4'h1;
            if (txTick_q == OVS_LAST)
            begin
              txShift_q <= {1'b1, txShift_q[7:1]};
              txBit_q <= txBit_q + 3'h1;
              if (txBit_q == LAST_BIT)
                txState_q <= S_STOP;
            end
          end
        S_STOP:
          if (tick)
          begin
            txTick_q <= txTick_q + 4'h1;
            if (txTick_q == OVS_LAST)
              txState_q <= S_IDLE;
          end
        default:
          txState_q <= S_IDLE;
      endcase
    end
  end
  // bit level on the line, zero during start bit
  wire txLevel = (txState_q == S_START) ? 1'b0 : (txState_q == S_DATA) ? txShift_q[0] : 1'b1;
  wire irPulse = ~txLevel & (txTick_q < IR_PULSE_TICKS);
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      serialOut_q <= 1'b1;
      irOutN_q <= 1'b1;
    end
    else if (clockEnable)
    begin
      serialOut_q <= ctrl_q.irMode ? 1'b1 : txLevel;
      irOutN_q <= ctrl_q.irMode ? ~irPulse : 1'b1;
    end
  end
  assign serialOut = serialOut_q;
  assign irOutN = irOutN_q;
endmodule // uart_shadow_port

// >>> sim/uart_far_end.sv
// far-end serial and infrared transceiver model
`timescale 1ns/1ps
module uart_far_end (
  input wire logic clock, // system clock
  output logic serialIn, // serial line into the port
  output logic irIn, // infrared line into the port, idle low
  input wire logic serialOut, // serial line from the port
  input wire logic irOutN // infrared line from the port
);
  logic [7:0] got[$];

  // lines idle
  initial
  begin
    serialIn = 1'b1;
    irIn = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      serialIn <= f[i];
      repeat (15) @(posedge clock);
    end
  endtask

  // one infrared frame, a short high pulse marks each zero bit
  task automatic sendIr(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      irIn <= ~f[i];
      repeat (3) @(posedge clock);
      irIn <= 1'b0;
      repeat (12) @(posedge clock);
    end
  endtask

  always
  begin : serRx
    logic [7:0] b;
    @(negedge serialOut);
    repeat (8) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge clock);
      b[i] = serialOut;
    end
    got.push_back(b);
  end

  always
  begin : irRx
    logic [7:0] b;
    @(negedge irOutN);
    repeat (15) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = 1'b1;
      repeat (16)
      begin
        @(posedge clock);
        if (!irOutN) b[i] = 1'b0;
      end
    end
    got.push_back(b);
  end
endmodule // uart_far_end

// >>> sim/uart_shadow_props.sv
// port-level assertions for the uart shadow data port
`timescale 1ns/1ps
module uart_shadow_props
  import uart_shadow_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rstn, // reset, active low
  input wire logic [31:0] address, // bus address
  input wire logic read, // bus read
  input wire logic write, // bus write
  input wire logic [31:0] readdata, // bus read data
  input wire logic waitrequest, // bus wait
  input wire logic serialOut, // serial tx
  input wire logic irOutN, // infrared tx
  input wire logic irq // interrupt
);
  default clocking cb
    @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // bus handshake and data
  a_write_nowait: assert property (write |-> !waitrequest)
    else $error("write stalled");
  a_read_answer: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read answer late");
  a_upper_zero: assert property (read && !waitrequest && address == DATA_ADDR |-> readdata[31:8] == 24'h0)
    else $error("upper bits not zero");
  a_data_stands: assert property (!read |=> $stable(readdata))
    else $error("read data moved");
  // sticky interrupt
  a_irq_sticky: assert property (irq && !write |=> irq)
    else $error("irq dropped");
  // line shapes
  a_start_width: assert property ($fell(serialOut) |-> !serialOut [*8])
    else $error("short serial bit");
  a_ir_pulse: assert property ($fell(irOutN) |-> !irOutN [*3])
    else $error("short ir pulse");
  a_one_line: assert property (!serialOut |-> irOutN)
    else $error("both lines active");
endmodule // uart_shadow_props

bind uart_shadow_port uart_shadow_props u_props (
  .clock,
  .rstn,
  .address,
  .read,
  .write,
  .readdata,
  .waitrequest,
  .serialOut,
  .irOutN,
  .irq
);

// >>> sim/tb_top.sv
// self-checking bench for the uart shadow data port
`timescale 1ns/1ps
module tb_top;
  import uart_shadow_pkg::*;
  logic clock, rstn, clockEnable, read, write, waitrequest;
  logic serialIn, irIn, serialOut, irOutN, irq;
  logic [31:0] address, writedata, readdata, d;
  logic [3:0] byteenable;
  int errCount, checkCount;

  uart_shadow_port #(.RX_DEPTH(4), .TX_DEPTH(4)) u_dut (
    .clock, .rstn, .clockEnable, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .serialIn, .irIn, .serialOut, .irOutN, .irq
  );
  uart_far_end u_far (.clock, .serialIn, .irIn, .serialOut, .irOutN);

  // clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checkCount++;
    if (s !== e)
    begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // bus write, held until waitrequest low
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest);
    write <= 1'b0;
  endtask

  // bus read, data taken at the completing edge
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest);
    v = readdata;
    read <= 1'b0;
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  // wait for one byte at the far end
  task automatic getb(input logic [7:0] e);
    int n;
    n = 0;
    while (u_far.got.size() == 0 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    chk(u_far.got.size() ? {24'h0, u_far.got.pop_front()} : 32'h1ff, {24'h0, e});
  endtask

  // reset values, unmapped and read-only places
  task automatic t_regs;
    rc(CTRL_ADDR, 32'h0);
    rc(DIV_ADDR, 32'h4);
    rc(IMASK_ADDR, 32'h0);
    rc(LINE_ADDR, 32'h60);
    rc(DATA_ADDR, 32'h0);
    rc(32'h5000_1200, 32'h0);
    wr(LINE_ADDR, 32'hff);
    rc(LINE_ADDR, 32'h60);
    wr(DIV_ADDR, 32'h1);
  endtask

  // single buffer overwrite, overrun, interrupt
  task automatic t_rx_single;
    u_far.send(8'ha5);
    u_far.send(8'h3c);
    rc(LINE_ADDR, 32'h61);
    rc(DATA_ADDR, 32'h3c);
    rd(ISTAT_ADDR, d);
    chk(d & 32'h3, 32'h3);
    wr(IMASK_ADDR, 32'h2);
    @(posedge clock);
    chk(irq, 32'h1);
    wr(ISTAT_ADDR, 32'hf);
    @(posedge clock);
    chk(irq, 32'h0);
  endtask

  // clock enable low freezes the registers
  task automatic t_freeze;
    @(posedge clock);
    clockEnable <= 1'b0;
    wr(IMASK_ADDR, 32'hf);
    clockEnable <= 1'b1;
    rc(IMASK_ADDR, 32'h2);
  endtask

  // receive fifo order and full drop
  task automatic t_rx_fifo;
    wr(CTRL_ADDR, 32'h1);
    for (int i = 0; i < 5; i++) u_far.send(8'h10 + 8'(i));
    for (int i = 0; i < 4; i++) rc(DATA_ADDR, 32'h10 + 32'(i));
    rc(DATA_ADDR, 32'h0);
    rd(ISTAT_ADDR, d);
    chk(d & 32'h2, 32'h2);
  endtask

  // transmit fifo fill, lost writes
  task automatic t_tx_fifo;
    for (int i = 0; i < 7; i++) wr(DATA_ADDR, 32'hffff_ff20 + 32'(i));
    rd(LINE_ADDR, d);
    chk(d & 32'h20, 32'h0);
    for (int i = 0; i < 5; i++) getb(8'h20 + 8'(i));
    rd(ISTAT_ADDR, d);
    chk(d & 32'h8, 32'h8);
  endtask

  // single holding register overwrite
  task automatic t_tx_single;
    wr(CTRL_ADDR, 32'h0);
    // wait until holding empty and line idle
    do rd(LINE_ADDR, d); while (d[6:5] != 2'b11);
    wr(DATA_ADDR, 32'h41);
    wr(DATA_ADDR, 32'h42);
    rc(LINE_ADDR, 32'h0);
    wr(DATA_ADDR, 32'h43);
    getb(8'h41);
    getb(8'h43);
  endtask

  // infrared receive and transmit
  task automatic t_ir;
    wr(CTRL_ADDR, 32'h2);
    u_far.sendIr(8'h5a);
    rc(DATA_ADDR, 32'h5a);
    wr(DATA_ADDR, 32'h96);
    getb(8'h96);
  endtask

  // verdict
  task automatic endSim;
    if (errCount == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0;
    clockEnable = 1'b1;
    address = 32'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_regs;
    t_rx_single;
    t_freeze;
    t_rx_fifo;
    t_tx_fifo;
    t_tx_single;
    t_ir;
    endSim;
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    errCount++;
    endSim;
  end
endmodule // tb_top
